/* File: rtl/opc_operate_state_query_ctrl.sv */
// Purpose: Operation-complete command and query, operate command and state query
// Assumes: A parser upstream presents one decoded command with cmd_valid
// Notes:   Port select only steers which port gets the reply
// Operation
// [RL1] Completion command sets event status bit 0 once nothing is pending
// [RL2] Completion query replies the character 1 after all pending work ends
// [RL3] No reply to the completion query while any operation is pending
// [RL4] Host waits for the query reply before sending more commands
// [RL5] Both commands taken from either port; they finish before the next
// [RL6] Operate command enters operate mode and connects output to terminals
// [RL7] Operate command acts as the front panel operate key in standby
// [RL8] Entering operate mode lights the operate indicator on the display
// [RL9] Operate command from either port runs overlapped with later commands
// [RL10] Operate state query replies 1 in operate mode and 0 in standby
// [RL11] Pending flag set while an overlapped command runs, drives completion
`timescale 1ns/1ps
`include "opc_operate_state_query_defines.svh"
module opc_operate_state_query_ctrl #(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // Decoded command
  input  wire logic                 cmd_valid,
  input  wire opc_operate_state_query_pkg::cmd_e   cmd_code,
  input  wire logic                 cmd_port,
  output logic                      cmd_ready,
  // Front panel key, asynchronous pin
  input  wire logic                 operate_key,
  // Status and reply
  output logic                      esr_opc_set,
  output logic                      reply_valid,
  output logic [7:0]                reply_char,
  output logic                      reply_port,
  // Output path
  output logic                      operate_mode,
  output logic                      output_connect,
  output logic                      operate_indicator,
  output logic                      op_pending
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  opc_operate_state_query_pkg::seq_e seq_q, seq_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic key_s1_q, key_s2_q, key_s3_q;
  logic operate_state_query_q, operate_state_query_d, pend_q, pend_d;
  logic esr_q, esr_d, rv_q, rv_d, rp_q, rp_d, rdy_q, rdy_d;
  logic [7:0] rc_q, rc_d;
  logic key_rise, take, start_operate_state_query;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      key_s3_q <= 1'b0;
    end else begin
      key_s1_q <= operate_key;
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
    end
  end
  assign key_rise = key_s2_q & ~key_s3_q;
  assign take = cmd_valid & rdy_q;
  // Operate key acts only from standby
  assign start_operate_state_query = (take && cmd_code == opc_operate_state_query_pkg::CMD_ENTER_OPERATE)
                    | (key_rise & ~operate_state_query_q); // [RL7]

  always_comb begin
    seq_d  = seq_q;
    cnt_d  = cnt_q;
    operate_state_query_d = operate_state_query_q;
    pend_d = pend_q;
    esr_d  = 1'b0;
    rv_d   = 1'b0;
    rc_d   = rc_q;
    rp_d   = rp_q;
    // Overlapped settle: pending while the output connects
    if (pend_q) begin
      if (cnt_q == CW'(1)) begin
        pend_d = 1'b0; // [RL11]
        cnt_d  = '0;
      end else begin
        cnt_d = cnt_q - CW'(1);
      end
    end
    if (start_operate_state_query) begin
      operate_state_query_d = 1'b1; // [RL6]
      pend_d = 1'b1; // [RL9] [RL11]
      cnt_d  = CW'(SETTLE_CYCLES);
    end
    if (take && cmd_code == opc_operate_state_query_pkg::CMD_STANDBY) begin
      operate_state_query_d = 1'b0;
    end
    case (seq_q)
      opc_operate_state_query_pkg::IDLE: begin
        if (take) begin
          rp_d = cmd_port; // [RL5]
          case (cmd_code)
            opc_operate_state_query_pkg::CMD_OPC:           seq_d = opc_operate_state_query_pkg::WAIT_OPC;
            opc_operate_state_query_pkg::CMD_OPC_QUERY:     seq_d = opc_operate_state_query_pkg::WAIT_QUERY;
            opc_operate_state_query_pkg::CMD_OPERATE_QUERY: begin
              rv_d = 1'b1;
              rc_d = operate_state_query_q ? `CHAR_ONE : `CHAR_ZERO; // [RL10]
            end
            default: ;
          endcase
        end
      end
      opc_operate_state_query_pkg::WAIT_OPC: begin
        if (!pend_q) begin
          esr_d = 1'b1; // [RL1]
          seq_d = opc_operate_state_query_pkg::IDLE;
        end
      end
      opc_operate_state_query_pkg::WAIT_QUERY: begin
        if (!pend_q) begin
          rv_d  = 1'b1; // [RL2] [RL3]
          rc_d  = `CHAR_ONE;
          seq_d = opc_operate_state_query_pkg::IDLE;
        end
      end
      default: seq_d = opc_operate_state_query_pkg::IDLE;
    endcase
    // Sequential commands block the next until done
    rdy_d = (seq_d == opc_operate_state_query_pkg::IDLE) && !(take && seq_q == opc_operate_state_query_pkg::IDLE
            && (cmd_code == opc_operate_state_query_pkg::CMD_OPC
             || cmd_code == opc_operate_state_query_pkg::CMD_OPC_QUERY)); // [RL5] [RL4]
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seq_q  <= opc_operate_state_query_pkg::IDLE;
      cnt_q  <= '0;
      operate_state_query_q <= 1'b0;
      pend_q <= 1'b0;
      esr_q  <= 1'b0;
      rv_q   <= 1'b0;
      rc_q   <= 8'h00;
      rp_q   <= 1'b0;
      rdy_q  <= 1'b0;
    end else begin
      seq_q  <= seq_d;
      cnt_q  <= cnt_d;
      operate_state_query_q <= operate_state_query_d;
      pend_q <= pend_d;
      esr_q  <= esr_d;
      rv_q   <= rv_d;
      rc_q   <= rc_d;
      rp_q   <= rp_d;
      rdy_q  <= rdy_d;
    end
  end

  assign cmd_ready         = rdy_q;
  assign esr_opc_set       = esr_q;
  assign reply_valid       = rv_q;
  assign reply_char        = rc_q;
  assign reply_port        = rp_q;
  assign operate_mode      = operate_state_query_q;
  assign output_connect    = operate_state_query_q; // [RL6]
  assign operate_indicator = operate_state_query_q; // [RL8]
  assign op_pending        = pend_q;

  // Assertions
  AST_OPC_ONLY_IDLE: assert property (@(posedge clock) disable iff (sys_rst) // [RL1]
    esr_opc_set |-> !$past(op_pending)) else $error("opc set while pending");
  AST_OPC_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // [RL1]
    (seq_q == opc_operate_state_query_pkg::WAIT_OPC && pend_q) |=> !esr_opc_set)
    else $error("opc set before work ended");
  AST_ESR_PULSE: assert property (@(posedge clock) disable iff (sys_rst) // [RL1]
    esr_opc_set |=> !esr_opc_set) else $error("opc set longer than one cycle");
  AST_QUERY_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // [RL3]
    (seq_q == opc_operate_state_query_pkg::WAIT_QUERY && pend_q) |=> !reply_valid)
    else $error("query answered while pending");
  AST_QUERY_ONE: assert property (@(posedge clock) disable iff (sys_rst) // [RL2]
    (seq_q == opc_operate_state_query_pkg::WAIT_QUERY && !pend_q) |=> reply_valid && reply_char == 8'h31)
    else $error("query reply missing or wrong");
  AST_QUERY_READY: assert property (@(posedge clock) disable iff (sys_rst) // [RL5]
    (seq_q == opc_operate_state_query_pkg::WAIT_QUERY && !pend_q) |=> cmd_ready)
    else $error("ready not back after reply");
  AST_OPERATE_STATE_QUERY_ENTER: assert property (@(posedge clock) disable iff (sys_rst) // [RL6]
    (take && cmd_code == opc_operate_state_query_pkg::CMD_ENTER_OPERATE) |=> operate_mode && output_connect)
    else $error("operate not entered");
  AST_INDICATOR: assert property (@(posedge clock) disable iff (sys_rst) // [RL8]
    (start_operate_state_query && !(take && cmd_code == opc_operate_state_query_pkg::CMD_STANDBY)) |=> operate_indicator)
    else $error("indicator off");
  AST_KEY_STANDBY: assert property (@(posedge clock) disable iff (sys_rst) // [RL7]
    (key_rise && !operate_state_query_q && !(take && cmd_code == opc_operate_state_query_pkg::CMD_STANDBY))
    |=> operate_mode && op_pending) else $error("key ignored");
  AST_STANDBY: assert property (@(posedge clock) disable iff (sys_rst) // [RL7]
    (take && cmd_code == opc_operate_state_query_pkg::CMD_STANDBY) |=> !operate_mode)
    else $error("standby not entered");
  AST_PEND_START: assert property (@(posedge clock) disable iff (sys_rst) // [RL11]
    start_operate_state_query |=> op_pending) else $error("pending not raised");
  AST_OVERLAP: assert property (@(posedge clock) disable iff (sys_rst) // [RL9]
    (take && cmd_code == opc_operate_state_query_pkg::CMD_ENTER_OPERATE && seq_q == opc_operate_state_query_pkg::IDLE)
    |=> cmd_ready) else $error("operate blocked commands");
  AST_STATE_Q: assert property (@(posedge clock) disable iff (sys_rst) // [RL10]
    (take && cmd_code == opc_operate_state_query_pkg::CMD_OPERATE_QUERY && seq_q == opc_operate_state_query_pkg::IDLE)
    |=> reply_valid && reply_char == ($past(operate_state_query_q) ? 8'h31 : 8'h30)) else $error("bad state");
  AST_REPLY_PORT: assert property (@(posedge clock) disable iff (sys_rst) // [RL5]
    (take && cmd_code == opc_operate_state_query_pkg::CMD_OPERATE_QUERY && seq_q == opc_operate_state_query_pkg::IDLE)
    |=> reply_port == $past(cmd_port)) else $error("reply on wrong port");
  AST_SEQ_BLOCK: assert property (@(posedge clock) disable iff (sys_rst) // [RL5]
    (take && cmd_code == opc_operate_state_query_pkg::CMD_OPC_QUERY) |=> !cmd_ready)
    else $error("query not sequential");
  AST_READY_WAIT: assert property (@(posedge clock) disable iff (sys_rst) // [RL5]
    (seq_q != opc_operate_state_query_pkg::IDLE) |-> !cmd_ready) else $error("ready while busy");
  AST_PEND_END: assert property (@(posedge clock) disable iff (sys_rst) // [RL11]
    (pend_q && cnt_q == CW'(1) && !start_operate_state_query) |=> !op_pending) else $error("pending stuck");

  // Main scenarios reached
  COV_OPC: cover property (@(posedge clock) esr_opc_set);
  COV_QUERY_WAIT: cover property (@(posedge clock)
    (seq_q == opc_operate_state_query_pkg::WAIT_QUERY && pend_q) ##[1:300] reply_valid);
  COV_KEY: cover property (@(posedge clock) key_rise && !operate_state_query_q);
  COV_OVERLAP: cover property (@(posedge clock)
    take && cmd_code == opc_operate_state_query_pkg::CMD_OPERATE_QUERY && pend_q);
  COV_STANDBY: cover property (@(posedge clock)
    take && cmd_code == opc_operate_state_query_pkg::CMD_STANDBY);
endmodule // opc_operate_state_query_ctrl

/* File: rtl/opc_operate_state_query_defines.svh */
// Purpose: Constants for the completion and operate command block
// Assumes: Commands arrive already decoded, one per cycle at most
// Notes:   Timing counts are in clock cycles at 250 MHz
`ifndef OPC_OPERATE_STATE_QUERY_DEFINES_SVH
`define OPC_OPERATE_STATE_QUERY_DEFINES_SVH
`define ESR_OPC_BIT        0
`define CLK_PERIOD_NS      4
`define SETTLE_TIME_NS     1000
`define SETTLE_CYCLES      ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHAR_ONE           8'h31
`define CHAR_ZERO          8'h30
`endif

/* File: rtl/opc_operate_state_query_pkg.sv */
// Purpose: Types for the completion and operate command block
// Assumes: Nothing beyond the defines header
// Notes:   Command codes are local to this block
package opc_operate_state_query_pkg;
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_OPC,
    CMD_OPC_QUERY,
    CMD_ENTER_OPERATE,
    CMD_OPERATE_QUERY,
    CMD_STANDBY
  } cmd_e;
  typedef enum logic [1:0] {
    IDLE,
    WAIT_OPC,
    WAIT_QUERY
  } seq_e;
endpackage

/* File: verification/host_model.sv */
// Purpose: Host controller model issuing decoded commands
// Assumes: A command is held until cmd_ready is high at an edge
// Notes:   Released lines show inverted values
`timescale 1ns/1ps
module host_model (
  // Clock and flow
  input  wire logic          clock,
  input  wire logic          cmd_ready,
  // Command
  output opc_operate_state_query_pkg::cmd_e cmd_code,
  output logic               cmd_valid,
  output logic               cmd_port
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = opc_operate_state_query_pkg::CMD_NONE;
    cmd_port  = 1'b0;
  end
  // Holds until taken, returns at the take edge
  task automatic send(input opc_operate_state_query_pkg::cmd_e c, input logic p);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_port  <= p;
    do @(posedge clock); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    cmd_code  <= opc_operate_state_query_pkg::cmd_e'(~c);
    cmd_port  <= ~p;
  endtask
endmodule // host_model

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the completion and operate block
// Assumes: Settle count shortened to 8 cycles
// Notes:   Replies are checked against a queue of notes
`timescale 1ns/1ps
module tb;
  localparam int SETTLE = 8;
  logic               clock, sys_rst, operate_key, cmd_valid, cmd_port, cmd_ready;
  logic               esr_opc_set, reply_valid, reply_port, operate_mode;
  logic               output_connect, operate_indicator, op_pending;
  logic [7:0]         reply_char;
  logic [31:0]        seed = 32'hF, cyc = 32'h0, t;
  logic [40:0]        r;
  logic [40:0]        rep_q[$];
  logic [31:0]        esr_q[$];
  int                 miscompares = 0, n_tests = 0;
  opc_operate_state_query_pkg::cmd_e cmd_code;
  opc_operate_state_query_ctrl #(.SETTLE_CYCLES(SETTLE)) opc_operate_state_query_ctrl_inst (
    .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_port(cmd_port), .cmd_ready(cmd_ready), .operate_key(operate_key),
    .esr_opc_set(esr_opc_set), .reply_valid(reply_valid), .reply_char(reply_char),
    .reply_port(reply_port), .operate_mode(operate_mode), .op_pending(op_pending),
    .output_connect(output_connect), .operate_indicator(operate_indicator));
  host_model host_model_inst (.clock(clock), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_port(cmd_port));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Sends from a random port and notes the awaited result
  task automatic ask(input opc_operate_state_query_pkg::cmd_e c, input logic [7:0] ch, input logic [31:0] lo);
    seed = xs(seed);
    host_model_inst.send(c, seed[0]);
    if (c == opc_operate_state_query_pkg::CMD_OPC) esr_q.push_back(lo);
    else rep_q.push_back({seed[0], ch, lo});
  endtask
  task automatic mode(input logic [3:0] e, input string nm);
    logic [7:0] g;
    g = {4'h0, operate_mode, output_connect, operate_indicator, op_pending};
    chk("mode", {4'h0, e}, g);
    $display("test %s done", nm);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'd3000) begin
      miscompares++;
      conclude();
    end
    if (reply_valid === 1'b1) begin
      chk("reply_noted", 8'h1, {7'h0, rep_q.size() != 0});
      r = rep_q.pop_front();
      chk("reply_char", r[39:32], reply_char);
      chk("reply_port", {7'h0, r[40]}, {7'h0, reply_port});
      chk("reply_late", 8'h1, {7'h0, cyc >= r[31:0]});
    end
    if (esr_opc_set === 1'b1) begin
      chk("esr_noted", 8'h1, {7'h0, esr_q.size() != 0});
      chk("esr_late", 8'h1, {7'h0, cyc >= esr_q.pop_front()});
    end
  end
  initial begin
    sys_rst = 1'b1;
    operate_key = 1'b0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    ask(opc_operate_state_query_pkg::CMD_OPC_QUERY, 8'h31, 0);
    ask(opc_operate_state_query_pkg::CMD_OPERATE_QUERY, 8'h30, 0);
    ask(opc_operate_state_query_pkg::CMD_OPC, 8'h0, 0);
    mode(4'h0, "idle");
    host_model_inst.send(opc_operate_state_query_pkg::CMD_ENTER_OPERATE, seed[1]);
    t = cyc;
    ask(opc_operate_state_query_pkg::CMD_OPERATE_QUERY, 8'h31, 0);
    chk("pending", 8'h1, {7'h0, op_pending});
    ask(opc_operate_state_query_pkg::CMD_OPC, 8'h0, t + SETTLE + 2);
    host_model_inst.send(opc_operate_state_query_pkg::CMD_ENTER_OPERATE, seed[2]);
    t = cyc;
    ask(opc_operate_state_query_pkg::CMD_OPC_QUERY, 8'h31, t + SETTLE + 2);
    @(posedge clock);
    chk("ready", 8'h0, {7'h0, cmd_ready});
    mode(4'hF, "operate");
    host_model_inst.send(opc_operate_state_query_pkg::CMD_STANDBY, seed[3]);
    ask(opc_operate_state_query_pkg::CMD_OPERATE_QUERY, 8'h30, 0);
    repeat (4) @(posedge clock);
    mode(4'h0, "standby");
    operate_key <= 1'b1;
    repeat (3) @(posedge clock);
    t = cyc;
    @(posedge clock);
    operate_key <= 1'b0;
    @(posedge clock);
    mode(4'hF, "key");
    ask(opc_operate_state_query_pkg::CMD_OPC_QUERY, 8'h31, t + SETTLE + 2);
    repeat (SETTLE + 8) @(posedge clock);
    chk("left", 8'h0, 8'(rep_q.size() + esr_q.size()));
    conclude();
  end
endmodule // tb
